// [rtl/fhd_pkg.sv]
// Shared constants and carrier types of the floppy host glue block
package fhd_pkg;

    // ------------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------------
    localparam int unsigned APB_AW      = 12;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STAT    = 12'h004;
    localparam logic [11:0] OFS_RDBYTE  = 12'h008;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK  = 32'h0000_FFFF;
    localparam logic [7:0]  RDBYTE_RST  = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned DOUT_DMA_EN_BIT = 3;
    localparam int unsigned STAT_EMPTY_BIT = 0;
    localparam int unsigned STAT_FULL_BIT  = 1;
    localparam int unsigned STAT_DMA_BIT   = 2;
    localparam int unsigned STAT_DENS_BIT  = 3;
    localparam int unsigned STAT_HD_BIT    = 4;
    localparam int unsigned STAT_OVR_BIT   = 5;
    localparam int unsigned STAT_LVL_LSB   = 8;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] COMPAT_OLD0 = 2'h0;
    localparam logic [1:0] COMPAT_OLD1 = 2'h1;
    localparam logic [1:0] COMPAT_NEW  = 2'h2;
    localparam logic [1:0] RATE_500K   = 2'h0;
    localparam logic [1:0] RATE_300K   = 2'h1;
    localparam logic [1:0] RATE_250K   = 2'h2;
    localparam logic [1:0] RATE_1M     = 2'h3;
    localparam logic [1:0] DENS_AUTO   = 2'h0;
    localparam logic [1:0] DENS_FORCE1 = 2'h1;
    localparam logic [1:0] DENS_FORCE0 = 2'h2;
    localparam logic [1:0] DENS_INVERT = 2'h3;

    // ------------------------------------------------------------------
    // Host address decode and FIFO size defaults
    // ------------------------------------------------------------------
    localparam logic [9:0] HOST_BASE_DFLT = 10'h100;
    localparam logic [2:0] HOST_DOUT_OFS  = 3'h2;
    localparam logic [2:0] HOST_DATA_OFS  = 3'h5;
    localparam int unsigned FIFO_W_DFLT   = 8;
    localparam int unsigned FIFO_D_DFLT   = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rsvd;
        logic        port_floppy_select_flag;
        logic        parallel_port_floppy_mode;
        logic [1:0]  dens_ctl;
        logic [1:0]  rate;
        logic [1:0]  compat;
        logic [7:0]  digital_output_reg;
    } fhd_ctrl_t;

    typedef struct packed {
        logic [9:0] addr;
        logic       aen;
        logic       rd_n;
        logic       wr_n;
        logic       dack_n;
        logic [7:0] data;
    } fhd_isa_t;

endpackage

// [rtl/fhd_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
module fhd_fifo #(
    parameter int unsigned WIDTH = fhd_pkg::FIFO_W_DFLT,
    parameter int unsigned DEPTH = fhd_pkg::FIFO_D_DFLT
) (
    input  wire logic                       mclk,      // System clock
    input  wire logic                       reset,     // Sync reset
    input  wire logic [WIDTH-1:0]           in_data,   // Write data
    input  wire logic                       in_valid,  // Write request
    output logic                            in_ready,  // Space available
    output logic [WIDTH-1:0]                out_data,  // Head word
    output logic                            out_valid, // Word available
    input  wire logic                       out_ready, // Drain accepts
    output logic [$clog2(DEPTH+1)-1:0]      level      // Words held
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wptr_r;
    logic [PW-1:0]    rptr_r;
    logic [LW-1:0]    cnt_r;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] fhd_inc(input logic [PW-1:0] p);
        fhd_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready  = (cnt_r != LW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rptr_r];
    assign level     = cnt_r;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else begin
            if (push) begin
                wptr_r <= fhd_inc(wptr_r);
            end
            if (pop) begin
                rptr_r <= fhd_inc(rptr_r);
            end
            if (push && !pop) begin
                cnt_r <= LW'(cnt_r + 1'b1);
            end else if (pop && !push) begin
                cnt_r <= LW'(cnt_r - 1'b1);
            end
        end
    end
endmodule

// [rtl/fhd_host_glue.sv]
// Host address qualification, DMA acknowledge gating and density select
// Summary of operation
// - Address lines ignored during honoured DMA transfer
// - AEN high blocks all address-based selection
// - DMA data register access ignores AEN
// - Low DACK enables strobes for DMA
// - Older modes honour DACK only with bit 3
// - Newer mode always honours DACK
// - High density at 500k/1M, low otherwise
// - Drive-type input sets density level polarity
// - Mode command can override density select
// - Parallel copy when floppy mode and flag 0
// - Data bus bit 0 LSB, bit 7 MSB
// - DRQ active high, gated like DACK
//
// Implementation choices: the address map and the APB slave port.
module fhd_host_glue #(
    parameter logic [9:0]  HOST_BASE = fhd_pkg::HOST_BASE_DFLT,
    parameter int unsigned FIFO_D    = fhd_pkg::FIFO_D_DFLT
) (
    input  wire logic                   mclk,               // 100 MHz clock
    input  wire logic                   reset,              // Sync, high
    input  wire logic [11:0]            paddr,              // APB address
    input  wire logic                   psel,               // APB select
    input  wire logic                   penable,            // APB enable
    input  wire logic                   pwrite,             // APB direction
    input  wire logic [31:0]            pwdata,             // APB wdata
    output logic [31:0]                 prdata,             // APB rdata
    output logic                        pready,             // APB ready
    output logic                        pslverr,            // APB error
    input  wire fhd_pkg::fhd_isa_t      isa,                // Host bus in
    output logic [7:0]                  host_data_out,      // Host rdata
    output logic                        host_data_oe,       // Drive D7-D0
    output logic                        func_sel,           // Decode hit
    input  wire logic                   dma_req_in,         // Core wants DMA
    output logic                        drq,                // DMA request
    output logic [7:0]                  core_data,          // Byte to core
    output logic                        core_valid,         // Byte present
    input  wire logic                   core_ready,         // Core takes
    input  wire logic                   ident,              // Drive type
    output logic                        density_select_out, // Density pin
    output logic                        pp_density_out,     // Parallel copy
    output logic                        pp_density_oe       // Copy enable
);
    localparam int unsigned LW = $clog2(FIFO_D + 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fhd_pkg::fhd_ctrl_t ctrl_r;
    logic [7:0]         rdbyte_r;
    logic               overrun_r;
    logic               wr_n_q_r;
    logic [7:0]         host_data_out_r;
    logic               dma_gate;
    logic               dack_honored;
    logic               addr_hit;
    logic               dout_hit;
    logic               data_hit;
    logic               wr_fall;
    logic               fifo_in_valid;
    logic               fifo_in_ready;
    logic [LW-1:0]      fifo_level;
    logic               high_density;
    logic               dens_auto;
    logic               apb_wr;
    logic               apb_rd;
    logic               ovr_set;
    logic               ovr_clr;
    logic [31:0]        stat_word;

    function automatic logic fhd_is_hd(input logic [1:0] rate);
        fhd_is_hd = (rate == fhd_pkg::RATE_500K) ||
                    (rate == fhd_pkg::RATE_1M);
    endfunction

    // ------------------------------------------------------------------
    // DMA acknowledge and request gating
    // ------------------------------------------------------------------
    // Newer mode treats output register bit 3 as reserved: no gating.
    assign dma_gate = (ctrl_r.compat == fhd_pkg::COMPAT_NEW) ||
                      ctrl_r.digital_output_reg[fhd_pkg::DOUT_DMA_EN_BIT];
    assign dack_honored = !isa.dack_n && dma_gate;
    // Request also waits for FIFO room, so DMA never outruns the core.
    assign drq = dma_req_in && dma_gate && fifo_in_ready;

    // ------------------------------------------------------------------
    // Address qualification
    // ------------------------------------------------------------------
    // An unhonoured low DACK falls back to plain decode; the host is
    // expected to keep DACK high during PIO anyway.
    assign addr_hit = !isa.aen &&
                      (isa.addr[9:3] == HOST_BASE[9:3]);
    assign dout_hit = !dack_honored && addr_hit &&
                      (isa.addr[2:0] == fhd_pkg::HOST_DOUT_OFS);
    assign data_hit = dack_honored ||
                      (addr_hit &&
                       (isa.addr[2:0] == fhd_pkg::HOST_DATA_OFS));
    assign func_sel = dout_hit || data_hit;

    // ------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_n_q_r <= 1'b1;
        end else begin
            wr_n_q_r <= isa.wr_n;
        end
    end

    assign wr_fall       = wr_n_q_r && !isa.wr_n;
    assign fifo_in_valid = wr_fall && data_hit;
    assign ovr_set       = fifo_in_valid && !fifo_in_ready;
    assign ovr_clr       = apb_wr && (paddr == fhd_pkg::OFS_STAT) &&
                           pwdata[fhd_pkg::STAT_OVR_BIT];

    // ------------------------------------------------------------------
    // Host read data
    // ------------------------------------------------------------------
    // Registered mux: data lags the decode by one cycle, well inside
    // any ISA read strobe.
    always_ff @(posedge mclk) begin
        if (reset) begin
            host_data_out_r <= 8'h00;
        end else if (dout_hit) begin
            host_data_out_r <= ctrl_r.digital_output_reg;
        end else if (data_hit) begin
            host_data_out_r <= rdbyte_r[7:0];
        end else begin
            host_data_out_r <= 8'h00;
        end
    end

    assign host_data_out = host_data_out_r;
    assign host_data_oe  = !isa.rd_n && func_sel;

    // ------------------------------------------------------------------
    // Data path buffer toward the controller core
    // ------------------------------------------------------------------
    fhd_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_data   (isa.data),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (core_data),
        .out_valid (core_valid),
        .out_ready (core_ready),
        .level     (fifo_level)
    );

    // ------------------------------------------------------------------
    // Density select
    // ------------------------------------------------------------------
    assign high_density = fhd_is_hd(ctrl_r.rate);
    assign dens_auto    = ident ? high_density : !high_density;

    always_comb begin
        case (ctrl_r.dens_ctl)
            fhd_pkg::DENS_AUTO:   density_select_out = dens_auto;
            fhd_pkg::DENS_FORCE1: density_select_out = 1'b1;
            fhd_pkg::DENS_FORCE0: density_select_out = 1'b0;
            fhd_pkg::DENS_INVERT: density_select_out = !dens_auto;
            default:              density_select_out = dens_auto;
        endcase
    end

    assign pp_density_oe  = ctrl_r.parallel_port_floppy_mode &&
                            !ctrl_r.port_floppy_select_flag;
    assign pp_density_out = pp_density_oe && density_select_out;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     (paddr != fhd_pkg::OFS_CTRL) &&
                     (paddr != fhd_pkg::OFS_STAT) &&
                     (paddr != fhd_pkg::OFS_RDBYTE);

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_r <= fhd_pkg::CTRL_RST;
        end else if (apb_wr && (paddr == fhd_pkg::OFS_CTRL)) begin
            ctrl_r <= pwdata & fhd_pkg::CTRL_WMASK;
        end else if (wr_fall && dout_hit) begin
            ctrl_r.digital_output_reg <= isa.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdbyte_r <= fhd_pkg::RDBYTE_RST;
        end else if (apb_wr && (paddr == fhd_pkg::OFS_RDBYTE)) begin
            rdbyte_r <= pwdata[7:0];
        end
    end

    // Overrun is write-one-to-clear; a new overrun beats the clear.
    always_ff @(posedge mclk) begin
        if (reset) begin
            overrun_r <= 1'b0;
        end else if (ovr_set) begin
            overrun_r <= 1'b1;
        end else if (ovr_clr) begin
            overrun_r <= 1'b0;
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[fhd_pkg::STAT_EMPTY_BIT] = !core_valid;
        stat_word[fhd_pkg::STAT_FULL_BIT]  = !fifo_in_ready;
        stat_word[fhd_pkg::STAT_DMA_BIT]   = dack_honored;
        stat_word[fhd_pkg::STAT_DENS_BIT]  = density_select_out;
        stat_word[fhd_pkg::STAT_HD_BIT]    = high_density;
        stat_word[fhd_pkg::STAT_OVR_BIT]   = overrun_r;
        stat_word[fhd_pkg::STAT_LVL_LSB +: LW] = fifo_level;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd && !penable) begin
            case (paddr)
                fhd_pkg::OFS_CTRL:   prdata <= ctrl_r;
                fhd_pkg::OFS_STAT:   prdata <= stat_word;
                fhd_pkg::OFS_RDBYTE: prdata <= {24'h00_0000, rdbyte_r};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_dma_addr_free: assert property (
        dack_honored |-> (data_hit && !dout_hit))
        else $error("address decode active during DMA");
    a_aen_blocks_sel: assert property (
        (isa.aen && !dack_honored) |-> !(dout_hit || data_hit))
        else $error("selection while AEN high");
    a_dma_aen_ok: assert property (
        (isa.aen && dack_honored && wr_fall) |-> fifo_in_valid)
        else $error("DMA write lost under AEN");
    a_dack_old_gate: assert property (
        ((ctrl_r.compat != fhd_pkg::COMPAT_NEW) &&
         !ctrl_r.digital_output_reg[fhd_pkg::DOUT_DMA_EN_BIT]) |->
        (!dack_honored && !drq))
        else $error("DACK honoured without output register bit 3");
    a_dack_new_mode: assert property (
        ((ctrl_r.compat == fhd_pkg::COMPAT_NEW) && !isa.dack_n)
        |-> dack_honored)
        else $error("DACK not honoured in newer mode");
    a_drq_cause: assert property (
        drq |-> (dma_req_in && fifo_in_ready))
        else $error("DRQ without core request or room");
    a_dens_auto_lvl: assert property (
        (ctrl_r.dens_ctl == fhd_pkg::DENS_AUTO) |->
        (density_select_out ==
         (ident ~^ ((ctrl_r.rate == fhd_pkg::RATE_500K) ||
                    (ctrl_r.rate == fhd_pkg::RATE_1M)))))
        else $error("density select level wrong");
    a_dens_forced: assert property (
        (ctrl_r.dens_ctl == fhd_pkg::DENS_FORCE0) |-> !density_select_out)
        else $error("forced density not low");
    a_pp_copy_pin: assert property (
        pp_density_oe |-> (pp_density_out == density_select_out))
        else $error("parallel density copy mismatch");
    a_dout_readback: assert property (
        (dout_hit && !$past(reset)) |=>
        (host_data_out == $past(ctrl_r.digital_output_reg)))
        else $error("output register read data misordered");
    a_ovr_set: assert property (
        ovr_set |=> overrun_r)
        else $error("overrun flag not set");
    // A clear in the cycle after an overrun is legal, so hold is per cycle
    a_ovr_sticky: assert property (
        (overrun_r && !ovr_clr) |=> overrun_r)
        else $error("overrun flag not held");
    a_dens_force1: assert property (
        (ctrl_r.dens_ctl == fhd_pkg::DENS_FORCE1) |-> density_select_out)
        else $error("forced density not high");
    a_dens_invert: assert property (
        (ctrl_r.dens_ctl == fhd_pkg::DENS_INVERT) |->
        (density_select_out !=
         (ident ~^ ((ctrl_r.rate == fhd_pkg::RATE_500K) ||
                    (ctrl_r.rate == fhd_pkg::RATE_1M)))))
        else $error("inverted density level wrong");
    a_low_rate: assert property (
        ((ctrl_r.rate == fhd_pkg::RATE_250K) ||
         (ctrl_r.rate == fhd_pkg::RATE_300K)) |-> !high_density)
        else $error("low rate flagged as high density");
    a_dma_rd_strobe: assert property (
        (dack_honored && !isa.rd_n) |-> host_data_oe)
        else $error("read strobe not enabled during DMA");
    a_rd_oe_idle: assert property (
        isa.rd_n |-> !host_data_oe)
        else $error("data bus driven without read strobe");
endmodule

// [verification/fhd_isa_host_model.sv]
// Host processor and DMA controller model on the ISA-style bus
module fhd_isa_host_model (
    input  wire logic         mclk, // System clock
    output fhd_pkg::fhd_isa_t isa   // Bus towards the device
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        isa = '{addr: 10'h3FF, aen: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                dack_n: 1'b1, data: 8'hFF};
    end

    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // Levels change just after an edge and hold until the next call
    task automatic drive(input logic [9:0] a, input logic en,
                         input logic dk, input logic rd);
        @(posedge mclk);
        isa.addr   <= a;
        isa.aen    <= en;
        isa.dack_n <= dk;
        isa.rd_n   <= rd;
    endtask

    // Write strobe of one cycle; wr_n is high again before the next call
    task automatic write(input logic [9:0] a, input logic en,
                         input logic dk, input logic [7:0] d);
        drive(a, en, dk, 1'b1);
        isa.data <= d;
        @(posedge mclk);
        isa.wr_n <= 1'b0;
        @(posedge mclk);
        isa.wr_n   <= 1'b1;
        isa.dack_n <= 1'b1;
        // Released lines must not look like a held value
        isa.data   <= ~d;
    endtask
endmodule

// [verification/fdc_host_dma_density_select_tb_top.sv]
// Self-checking bench of the floppy host glue block
module fdc_host_dma_density_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] DOUT_A =
        fhd_pkg::HOST_BASE_DFLT + 10'(fhd_pkg::HOST_DOUT_OFS);
    localparam logic [9:0] DAT_A =
        fhd_pkg::HOST_BASE_DFLT + 10'(fhd_pkg::HOST_DATA_OFS);
    logic              mclk, reset, psel, penable, pwrite, pready;
    logic              pslverr, host_data_oe, func_sel, dma_req_in;
    logic              drq, core_valid, core_ready, ident, dens;
    logic              pp_out, pp_oe, err, hon, pp, pn, ex;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [7:0]        host_data_out, core_data, b;
    fhd_pkg::fhd_isa_t isa;
    int                n_mismatch, n_compared, seed;
    logic [7:0]        q[$];

    fhd_host_glue dut (.mclk(mclk), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .isa(isa),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .func_sel(func_sel), .dma_req_in(dma_req_in), .drq(drq),
        .core_data(core_data), .core_valid(core_valid),
        .core_ready(core_ready), .ident(ident),
        .density_select_out(dens), .pp_density_out(pp_out),
        .pp_density_oe(pp_oe));
    fhd_isa_host_model host (.mclk(mclk), .isa(isa));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // --------------------------------------------------------------
    // Shared tasks and reference model
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ends one idle cycle after the access so psel is never set twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog ends a slave that never answers
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    function automatic logic dens_exp(input logic [1:0] r, c,
                                      input logic id);
        logic lv;
        lv = (r == fhd_pkg::RATE_500K || r == fhd_pkg::RATE_1M) == id;
        case (c)
            fhd_pkg::DENS_FORCE1: lv = 1'b1;
            fhd_pkg::DENS_FORCE0: lv = 1'b0;
            fhd_pkg::DENS_INVERT: lv = !lv;
            default: ;
        endcase
        return lv;
    endfunction

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial begin
        seed = 32'h778f;
        n_mismatch = 0;
        n_compared = 0;
        reset = 1'b1;
        {psel, penable, pwrite, dma_req_in, core_ready, ident} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(1'b0, fhd_pkg::OFS_CTRL, '0);
        chk(rd, fhd_pkg::CTRL_RST);
        apb(1'b0, fhd_pkg::OFS_RDBYTE, '0);
        chk(rd, {24'h0, fhd_pkg::RDBYTE_RST});
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        // Every rate, density control and drive type
        for (int i = 0; i < 32; i++) begin
            {pp, pn} = 2'($random(seed));
            ident <= i[4];
            ex = dens_exp(i[1:0], i[3:2], i[4]);
            apb(1'b1, fhd_pkg::OFS_CTRL,
                {16'h0, pn, pp, i[3:2], i[1:0], 10'h0});
            chk(32'(dens), 32'(ex));
            chk(32'(pp_oe), 32'(pp && !pn));
            if (pp && !pn) chk(32'(pp_out), 32'(ex));
            apb(1'b0, fhd_pkg::OFS_STAT, '0);
            chk(32'(rd[fhd_pkg::STAT_DENS_BIT]), 32'(ex));
        end
        // Acknowledge gating in each mode, with and without gate bit 3
        dma_req_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            hon = (i / 2 == 2) || i[0];
            apb(1'b1, fhd_pkg::OFS_CTRL, {22'h0, 2'(i / 2), 4'h0, i[0], 3'h0});
            host.drive(10'($random(seed)), 1'b1, 1'b0, 1'b1);
            @(posedge mclk);
            chk(32'(func_sel), 32'(hon));
            chk(32'(drq), 32'(hon));
            host.drive(DOUT_A, 1'b1, 1'b1, 1'b1);
            @(posedge mclk);
            chk(32'(func_sel), 32'h0);
            host.drive(DOUT_A, 1'b0, 1'b1, 1'b1);
            @(posedge mclk);
            chk(32'(func_sel), 32'h1);
        end
        // Fill past full with the core stalled, then drain in order
        for (int i = 0; i < 5; i++) begin
            b = 8'($random(seed));
            if (i < 4) q.push_back(b);
            if (i == 0) host.write(DAT_A, 1'b0, 1'b1, b);
            else host.write(10'($random(seed)), 1'($random(seed)), 1'b0, b);
        end
        @(posedge mclk);
        chk(32'(drq), 32'h0);
        apb(1'b0, fhd_pkg::OFS_STAT, '0);
        chk(rd & 32'h0723, 32'h0422);
        apb(1'b1, fhd_pkg::OFS_STAT, 32'h20);
        apb(1'b0, fhd_pkg::OFS_STAT, '0);
        chk(rd & 32'h20, 32'h0);
        while (q.size() > 0) begin
            chk(32'(core_valid), 32'h1);
            chk(32'(core_data), 32'(q.pop_front()));
            core_ready <= 1'b1;
            @(posedge mclk);
            core_ready <= 1'b0;
            @(posedge mclk);
        end
        chk(32'(core_valid), 32'h0);
        // Programmed read of the data register, then blocked by AEN
        b = 8'($random(seed));
        apb(1'b1, fhd_pkg::OFS_RDBYTE, {24'h0, b});
        host.drive(DAT_A, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        chk({23'h0, host_data_oe, host_data_out}, {24'h1, b});
        host.drive(DAT_A, 1'b1, 1'b1, 1'b0);
        @(posedge mclk);
        chk(32'(host_data_oe), 32'h0);
        host.drive(DAT_A, 1'b1, 1'b1, 1'b1);
        // Host write of the output register, seen on APB and the host bus
        b = 8'($random(seed));
        host.write(DOUT_A, 1'b0, 1'b1, b);
        apb(1'b0, fhd_pkg::OFS_CTRL, '0);
        chk(32'(rd[7:0]), 32'(b));
        host.drive(DOUT_A, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        chk({23'h0, host_data_oe, host_data_out}, {24'h1, b});
        host.drive(DOUT_A, 1'b0, 1'b1, 1'b1);
        final_report();
    end
endmodule
